// ==== pcse_cfg.svh ====
// Constants of the clock-select and channel-enable front end.
// Assumes byte-wide registers reached on an 8-bit address port.
`ifndef PCSE_CFG_SVH
`define PCSE_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PCSE_OFS_CLK 8'h40
`define PCSE_OFS_POL 8'h41
`define PCSE_OFS_EN 8'h42
`define PCSE_OFS_PRES 8'h43
`define PCSE_OFS_SCAL0 8'h44
`define PCSE_OFS_SCNT0 8'h45
`define PCSE_OFS_SCAL1 8'h46
`define PCSE_OFS_SCNT1 8'h47
`define PCSE_OFS_TEST 8'h54

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCSE_CLK_PAIR_UP 7
`define PCSE_CLK_PAIR_LO 6
`define PCSE_CLK_PA_LSB 3
`define PCSE_CLK_PB_LSB 0
`define PCSE_POL_CHOICE_LSB 4
`define PCSE_POL_POL_LSB 0
`define PCSE_TEST_LOAD_DIS 3

// ----------------------------------------
// Reset values and the prescaler all-ones mask
// ----------------------------------------
`define PCSE_RST_CLK 8'h00
`define PCSE_RST_POL 8'h00
`define PCSE_RST_EN 4'h0
`define PCSE_RST_PRES 7'h00
`define PCSE_RST_SCAL 8'h00
`define PCSE_PRES_ALL 7'h7f

`endif

// ==== pcse_pkg.sv ====
// Types shared by the front end and its surroundings.
// Constants live in pcse_cfg.svh.
package pcse_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pcse_req_s;

    typedef struct packed {
        logic [7:0] clk_cfg;
        logic [7:0] pol_cfg;
        logic [3:0] en;
        logic [6:0] pres;
        logic [7:0] scal0;
        logic [7:0] scnt0;
        logic [7:0] scal1;
        logic [7:0] scnt1;
        logic half0;
        logic half1;
        logic load_dis;
        logic sm_meta;
        logic sm;
        logic [3:0] live;
        logic [3:0] clk_en;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic [3:0] pol_out;
        logic [1:0] pair;
        logic [7:0] rdata;
    } pcse_state_s;

endpackage

// ==== pcse_top.sv ====
// Clock generation and channel control in front of four PWM counters.
// Assumes counters on ref_clk that deliver a raw duty level per channel
// (0 before the duty match, 1 after) and take clk_en as their tick.
//
// Operation
// - Pairing bit for channels 2/3 forms one 16-bit channel, 2 upper.
// - Paired 2/3 drives pin 2 and is clocked by channel 3's choice.
// - Pairing bit for channels 0/1 forms one 16-bit channel, 0 upper.
// - Paired 0/1 drives pin 0 and is clocked by channel 1's choice.
// - Clock A is bus clock over two to the prescale field, 1..128.
// - Clock B uses its own prescale field, same encoding as A.
// - Channels 2/3 choose clock B at 0, scaled B at 1.
// - Channels 0/1 choose clock A at 0, scaled A at 1.
// - Polarity 0 starts low then high at duty; 1 the reverse.
// - Left aligned, duty counts low time at 0, high time at 1.
// - Enable forces the pin to output (not pins 1/3 when paired), direction bit untouched.
// - Enable cleared returns pin direction to the direction bit.
// - Clock reaches a channel only while enabled, gated at edges.
// - All enables clear stops the prescaler counter.
// - Waveform appears at the next cycle of the selected clock.
// - Prescaler is a readable free 7-bit counter, written in special mode.
// - Scale register 0 write loads counter unless special and load disabled.
// - Scaled A is clock A over scale 0 plus one, then halved.
// - Scale counters count down and reload at zero.
// - Scaled B is clock B over scale 1 plus one, then halved.
`timescale 1ns/1ps

module pcse_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire pcse_pkg::pcse_req_s req,
    input wire logic special_mode_pin,
    input wire logic [3:0] port_direction_register,
    input wire logic [3:0] port_data,
    input wire logic [3:0] chan_wave,
    output logic [7:0] rdata,
    output logic [3:0] chan_clk_en,
    output logic [3:0] chan_polarity,
    output logic [1:0] pair_flags,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe
);
    import pcse_pkg::*;
`include "pcse_cfg.svh"

    pcse_state_s s_reg;
    pcse_state_s s_next;

    // ----------------------------------------
    // Decoded views of the current state
    // ----------------------------------------
    logic [2:0] pa;
    logic [2:0] pb;
    logic [6:0] mask_a;
    logic [6:0] mask_b;
    logic run;
    logic tick_a;
    logic tick_b;
    logic tick_sa;
    logic tick_sb;
    logic [3:0] choice;
    logic [3:0] tick_ch;
    logic [3:0] owned;

    always_comb begin
        pa = s_reg.clk_cfg[`PCSE_CLK_PA_LSB +: 3];
        pb = s_reg.clk_cfg[`PCSE_CLK_PB_LSB +: 3];
        choice = s_reg.pol_cfg[`PCSE_POL_CHOICE_LSB +: 4];
        // Low bits all ones marks one pulse per 2^n cycles
        mask_a = ~(`PCSE_PRES_ALL << pa);
        mask_b = ~(`PCSE_PRES_ALL << pb);
        run = |s_reg.en;
        tick_a = run && ((s_reg.pres & mask_a) == mask_a);
        tick_b = run && ((s_reg.pres & mask_b) == mask_b);
        // Scaled pulse on every second reload
        tick_sa = tick_a && (s_reg.scnt0 == 8'h00) && s_reg.half0;
        tick_sb = tick_b && (s_reg.scnt1 == 8'h00) && s_reg.half1;
        tick_ch[0] = choice[0] ? tick_sa : tick_a;
        tick_ch[1] = choice[1] ? tick_sa : tick_a;
        tick_ch[2] = choice[2] ? tick_sb : tick_b;
        tick_ch[3] = choice[3] ? tick_sb : tick_b;
        // Paired upper byte follows the lower channel's clock
        if (s_reg.clk_cfg[`PCSE_CLK_PAIR_LO]) begin
            tick_ch[0] = tick_ch[1];
        end
        if (s_reg.clk_cfg[`PCSE_CLK_PAIR_UP]) begin
            tick_ch[2] = tick_ch[3];
        end
        owned = s_reg.en;
        // Lower byte of a pair gives its pin back to the port
        if (s_reg.clk_cfg[`PCSE_CLK_PAIR_LO]) begin
            owned[1] = 1'b0;
        end
        if (s_reg.clk_cfg[`PCSE_CLK_PAIR_UP]) begin
            owned[3] = 1'b0;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.clk_en = 4'h0;
        s_next.rdata = 8'h00;
        // Mode pin is asynchronous: two flops before use
        s_next.sm_meta = special_mode_pin;
        s_next.sm = s_reg.sm_meta;

        // Prescaler halts with all channels off to save power
        if (run) begin
            s_next.pres = s_reg.pres + 7'h01;
        end

        // Scale counters step on their source clock
        if (tick_a) begin
            if (s_reg.scnt0 == 8'h00) begin
                s_next.scnt0 = s_reg.scal0;
                s_next.half0 = ~s_reg.half0;
            end else begin
                s_next.scnt0 = s_reg.scnt0 - 8'h01;
            end
        end
        if (tick_b) begin
            if (s_reg.scnt1 == 8'h00) begin
                s_next.scnt1 = s_reg.scal1;
                s_next.half1 = ~s_reg.half1;
            end else begin
                s_next.scnt1 = s_reg.scnt1 - 8'h01;
            end
        end

        // Channel clock gating, live waveform and pins
        for (int i = 0; i < 4; i++) begin
            s_next.clk_en[i] = s_reg.en[i] & tick_ch[i];
            if (!s_reg.en[i]) begin
                s_next.live[i] = 1'b0;
            end else if (tick_ch[i]) begin
                s_next.live[i] = 1'b1;
            end
            s_next.pin_oe[i] = owned[i] | port_direction_register[i];
            if (!owned[i]) begin
                s_next.pin_out[i] = port_data[i];
            end else if (s_reg.live[i]) begin
                // Raw level flips at duty; polarity picks the start level
                s_next.pin_out[i] = chan_wave[i] ^ s_reg.pol_cfg[i];
            end else begin
                s_next.pin_out[i] = s_reg.pol_cfg[i];
            end
        end
        s_next.pol_out = s_reg.pol_cfg[`PCSE_POL_POL_LSB +: 4];
        s_next.pair[1] = s_reg.clk_cfg[`PCSE_CLK_PAIR_UP];
        s_next.pair[0] = s_reg.clk_cfg[`PCSE_CLK_PAIR_LO];

        // Test bits exist only in special mode
        if (!s_reg.sm) begin
            s_next.load_dis = 1'b0;
        end

        // Register writes win over counting in the same cycle
        if (req.wr) begin
            if (req.addr == `PCSE_OFS_CLK) begin
                s_next.clk_cfg = req.wdata;
            end else if (req.addr == `PCSE_OFS_POL) begin
                // Clock choice may glitch one pulse if changed live
                s_next.pol_cfg = req.wdata;
            end else if (req.addr == `PCSE_OFS_EN) begin
                s_next.en = req.wdata[3:0];
            end else if (req.addr == `PCSE_OFS_PRES) begin
                if (s_reg.sm) begin
                    s_next.pres = req.wdata[6:0];
                end
            end else if (req.addr == `PCSE_OFS_SCAL0) begin
                s_next.scal0 = req.wdata;
                if (!(s_reg.sm && s_reg.load_dis)) begin
                    s_next.scnt0 = req.wdata;
                end
            end else if (req.addr == `PCSE_OFS_SCAL1) begin
                s_next.scal1 = req.wdata;
                if (!(s_reg.sm && s_reg.load_dis)) begin
                    s_next.scnt1 = req.wdata;
                end
            end else if (req.addr == `PCSE_OFS_TEST) begin
                if (s_reg.sm) begin
                    s_next.load_dis = req.wdata[`PCSE_TEST_LOAD_DIS];
                end
            end
        end

        // Read data stand in the cycle after the strobe
        if (req.rd) begin
            if (req.addr == `PCSE_OFS_CLK) begin
                s_next.rdata = s_reg.clk_cfg;
            end else if (req.addr == `PCSE_OFS_POL) begin
                s_next.rdata = s_reg.pol_cfg;
            end else if (req.addr == `PCSE_OFS_EN) begin
                s_next.rdata = {4'h0, s_reg.en};
            end else if (req.addr == `PCSE_OFS_PRES) begin
                s_next.rdata = {1'b0, s_reg.pres};
            end else if (req.addr == `PCSE_OFS_SCAL0) begin
                s_next.rdata = s_reg.scal0;
            end else if (req.addr == `PCSE_OFS_SCNT0) begin
                s_next.rdata = s_reg.scnt0;
            end else if (req.addr == `PCSE_OFS_SCAL1) begin
                s_next.rdata = s_reg.scal1;
            end else if (req.addr == `PCSE_OFS_SCNT1) begin
                s_next.rdata = s_reg.scnt1;
            end else if (req.addr == `PCSE_OFS_TEST) begin
                s_next.rdata = {4'h0, s_reg.load_dis, 3'h0};
            end
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.clk_cfg <= `PCSE_RST_CLK;
            s_reg.pol_cfg <= `PCSE_RST_POL;
            s_reg.en <= `PCSE_RST_EN;
            s_reg.pres <= `PCSE_RST_PRES;
            s_reg.scal0 <= `PCSE_RST_SCAL;
            s_reg.scnt0 <= `PCSE_RST_SCAL;
            s_reg.scal1 <= `PCSE_RST_SCAL;
            s_reg.scnt1 <= `PCSE_RST_SCAL;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign chan_clk_en = s_reg.clk_en;
    assign chan_polarity = s_reg.pol_out;
    assign pair_flags = s_reg.pair;
    assign pin_out = s_reg.pin_out;
    assign pin_oe = s_reg.pin_oe;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_PAIR_UP_FLAG: assert property (
        ##1 pair_flags[1] == $past(s_reg.clk_cfg[`PCSE_CLK_PAIR_UP]))
        else $error("upper pair flag wrong");

    AST_PAIR_LO_FLAG: assert property (
        ##1 pair_flags[0] == $past(s_reg.clk_cfg[`PCSE_CLK_PAIR_LO]))
        else $error("lower pair flag wrong");

    AST_PAIR_UP_CLK: assert property (
        s_reg.clk_cfg[`PCSE_CLK_PAIR_UP] && s_reg.en[2]
        |=> chan_clk_en[2] == $past(tick_ch[3]))
        else $error("paired upper clock not from channel 3");

    AST_PAIR_LO_PIN: assert property (
        s_reg.clk_cfg[`PCSE_CLK_PAIR_LO] && s_reg.en[1]
        && !port_direction_register[1] |=> !pin_oe[1])
        else $error("paired lower pin still owned");

    AST_PAIR_UP_PIN: assert property (
        s_reg.clk_cfg[`PCSE_CLK_PAIR_UP] && s_reg.en[3]
        && !port_direction_register[3] |=> !pin_oe[3])
        else $error("paired channel 3 pin still owned");

    AST_PAIR_LO_CLK: assert property (
        s_reg.clk_cfg[`PCSE_CLK_PAIR_LO] && s_reg.en[0]
        |=> chan_clk_en[0] == $past(tick_ch[1]))
        else $error("paired lower clock not from channel 1");

    AST_DIV_A: assert property (
        run && pa == 3'h7 |-> tick_a == (s_reg.pres == 7'h7f))
        else $error("clock A divide by 128 off grid");

    AST_DIV_B: assert property (
        run && pb == 3'h0 |-> tick_b)
        else $error("undivided clock B missed a cycle");

    AST_TICK_A_COUNT: assert property (
        run && pa == 3'h1 && tick_a && !req.wr |=> !tick_a)
        else $error("clock A divide by two broken");

    AST_SEL_B: assert property (
        s_reg.en[3] && !choice[3] && tick_b |=> chan_clk_en[3])
        else $error("channel 3 missed clock B");

    AST_SEL_B_SCALED: assert property (
        s_reg.en[3] && choice[3] |=> chan_clk_en[3] == $past(tick_sb))
        else $error("channel 3 not on scaled B");

    AST_SEL_A: assert property (
        s_reg.en[1] && choice[1] && !tick_sa |=> !chan_clk_en[1])
        else $error("channel 1 ticked without scaled A");

    AST_POL_IDLE: assert property (
        owned[0] && !s_reg.live[0] |=> pin_out[0] == $past(s_reg.pol_cfg[0]))
        else $error("pin 0 start level wrong");

    AST_POL_LIVE: assert property (
        owned[2] && s_reg.live[2] |=> pin_out[2] == $past(chan_wave[2] ^ s_reg.pol_cfg[2]))
        else $error("pin 2 live level wrong");

    AST_FORCE_OUT: assert property (
        s_reg.en[0] |=> pin_oe[0])
        else $error("enabled pin not output");

    AST_RELEASE: assert property (
        !s_reg.en[2] |=> pin_oe[2] == $past(port_direction_register[2]))
        else $error("released pin ignores direction bit");

    AST_GATE: assert property (
        !s_reg.en[0] |=> !chan_clk_en[0])
        else $error("disabled channel got clock");

    AST_PRES_STOP: assert property (
        !run && !(req.wr && req.addr == `PCSE_OFS_PRES) |=> $stable(s_reg.pres))
        else $error("prescaler ran with all channels off");

    AST_LIVE: assert property (
        s_reg.en[1] && tick_ch[1] ##1 s_reg.en[1] |-> s_reg.live[1])
        else $error("waveform not live after first tick");

    AST_PRES_RO: assert property (
        req.wr && req.addr == `PCSE_OFS_PRES && !s_reg.sm && !run
        |=> $stable(s_reg.pres))
        else $error("prescaler written outside special mode");

    AST_PRES_RUN: assert property (
        run && !req.wr |=> s_reg.pres == $past(s_reg.pres) + 7'h01)
        else $error("prescaler not free running");

    AST_SCAL_LOAD: assert property (
        req.wr && req.addr == `PCSE_OFS_SCAL0 && !s_reg.sm
        |=> s_reg.scnt0 == $past(req.wdata))
        else $error("scale counter not loaded");

    AST_SCAL_HOLD: assert property (
        req.wr && req.addr == `PCSE_OFS_SCAL0 && s_reg.sm && s_reg.load_dis
        && !tick_a |=> $stable(s_reg.scnt0))
        else $error("scale counter loaded while disabled");

    AST_TEST_NORMAL: assert property (
        !s_reg.sm |=> !s_reg.load_dis)
        else $error("load disable set outside special mode");

    AST_RELOAD: assert property (
        tick_a && s_reg.scnt0 == 8'h00 && !req.wr
        |=> s_reg.scnt0 == $past(s_reg.scal0) && s_reg.half0 != $past(s_reg.half0))
        else $error("scale counter reload wrong");

    AST_SCALED_B: assert property (
        tick_sb |-> tick_b && s_reg.half1 && s_reg.scnt1 == 8'h00)
        else $error("scaled B pulse without cause");

    AST_PULSE: assert property (
        !req.wr ##1 chan_clk_en[0] && s_reg.clk_cfg[`PCSE_CLK_PA_LSB +: 3] != 3'h0
        && !choice[0] && !s_reg.clk_cfg[`PCSE_CLK_PAIR_LO] |=> !chan_clk_en[0])
        else $error("divided enable longer than one cycle");

    AST_READ: assert property (
        req.rd && req.addr == `PCSE_OFS_SCAL0 |=> rdata == $past(s_reg.scal0))
        else $error("scale register read wrong");

    COV_PAIR_UP: cover property (
        s_reg.clk_cfg[`PCSE_CLK_PAIR_UP] && chan_clk_en[2]);
    COV_SCALED_A: cover property (tick_sa && s_reg.en[0]);
    COV_PAIR_LO: cover property (s_reg.clk_cfg[`PCSE_CLK_PAIR_LO] && chan_clk_en[0]);
    COV_ALL_OFF: cover property (run ##1 !run);
    COV_SPECIAL: cover property (
        req.wr && req.addr == `PCSE_OFS_PRES && s_reg.sm);

endmodule

// ==== pwm_clock_select_enable_tb_top.sv ====
// Self-checking bench for the clock-select and channel-enable front end.
// Assumes pcse_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`include "pcse_cfg.svh"

module pwm_clock_select_enable_tb_top;
    import pcse_pkg::*;

    typedef struct {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
        logic [1:0] p;
    } pcse_row_s;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    pcse_req_s req = '0;
    logic special_mode_pin = 1'b0;
    logic [3:0] port_direction_register = 4'h0;
    logic [3:0] port_data = 4'h0;
    logic [3:0] chan_wave = 4'h0;
    logic [7:0] rdata;
    logic [3:0] chan_clk_en;
    logic [3:0] chan_polarity;
    logic [1:0] pair_flags;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    int error_cnt = 0;
    int comparisons = 0;
    int cnt [4];
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] rv;
    logic [7:0] ofs [9] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h54};
    // Pairing flags follow the last write of the clock register
    pcse_row_s rows [12] = '{
        '{8'h40, 8'ha5, 8'ha5, 2'h2}, '{8'h40, 8'h40, 8'h40, 2'h1},
        '{8'h40, 8'hc0, 8'hc0, 2'h3}, '{8'h40, 8'h00, 8'h00, 2'h0},
        '{8'h41, 8'h3c, 8'h3c, 2'h0}, '{8'h41, 8'h00, 8'h00, 2'h0},
        '{8'h44, 8'h7e, 8'h7e, 2'h0}, '{8'h46, 8'h81, 8'h81, 2'h0},
        '{8'h54, 8'h08, 8'h00, 2'h0}, '{8'h50, 8'h11, 8'h00, 2'h0},
        '{8'h42, 8'h05, 8'h05, 2'h0}, '{8'h42, 8'h00, 8'h00, 2'h0}};

    always #50 ref_clk = ~ref_clk;

    pcse_top i_pcse_top (
        .ref_clk(ref_clk),
        .rst(rst),
        .req(req),
        .special_mode_pin(special_mode_pin),
        .port_direction_register(port_direction_register),
        .port_data(port_data),
        .chan_wave(chan_wave),
        .rdata(rdata),
        .chan_clk_en(chan_clk_en),
        .chan_polarity(chan_polarity),
        .pair_flags(pair_flags),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    // ----------------------------------------
    // Compare, bus and counting tasks
    // ----------------------------------------
    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t ticks %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("TB: compares %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge ref_clk);
        req.rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Window lengths are multiples of every tick period used
    task automatic count(input int n);
        cnt = '{default: 0};
        repeat (n) begin
            @(negedge ref_clk);
            foreach (cnt[i]) cnt[i] += int'(chan_clk_en[i] !== 1'b0);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rv);
            chk_v(rv, rows[i].e);
            chk_v(pair_flags, rows[i].p);
        end
        $display("TB: register rows done");

        // Prescaler stands still while all channels are off
        rd(`PCSE_OFS_PRES, p1);
        wr(`PCSE_OFS_PRES, p1 ^ 8'h7f);
        rd(`PCSE_OFS_PRES, p2);
        chk_v(p2, p1);
        @(posedge ref_clk);
        special_mode_pin <= 1'b1;
        settle(4);
        wr(`PCSE_OFS_PRES, 8'h33);
        rd(`PCSE_OFS_PRES, rv);
        chk_v(rv, 8'h33);
        // All enables are clear, so the prescaler holds 0x33 and clock A stays silent for these reads
        wr(`PCSE_OFS_CLK, 8'h38);
        wr(`PCSE_OFS_SCAL0, 8'h20);
        rd(`PCSE_OFS_SCNT0, rv);
        chk_v(rv, 8'h20);
        wr(`PCSE_OFS_TEST, 8'h08);
        wr(`PCSE_OFS_SCAL0, 8'h40);
        rd(`PCSE_OFS_SCNT0, rv);
        chk_v(rv, 8'h20);
        rd(`PCSE_OFS_SCAL0, rv);
        chk_v(rv, 8'h40);
        $display("TB: prescaler and scale load done");

        @(posedge ref_clk);
        port_direction_register <= 4'h4;
        port_data <= 4'h5;
        chan_wave <= 4'h2;
        wr(`PCSE_OFS_POL, 8'h02);
        settle(3);
        chk_v(pin_oe, 4'h4);
        chk_v(pin_out, 4'h5);
        wr(`PCSE_OFS_EN, 8'h02);
        settle(3);
        chk_v(pin_oe, 4'h6);
        chk_v(pin_out, 4'h7);
        chk_v(chan_polarity, 4'h2);
        settle(200);
        chk_v(pin_out, 4'h5);
        wr(`PCSE_OFS_POL, 8'h00);
        settle(3);
        chk_v(pin_out, 4'h7);
        wr(`PCSE_OFS_EN, 8'h00);
        settle(3);
        chk_v(pin_oe, 4'h4);
        chk_v(pin_out, 4'h5);
        $display("TB: pin ownership done");

        @(posedge ref_clk);
        special_mode_pin <= 1'b0;
        settle(4);
        wr(`PCSE_OFS_CLK, 8'h00);
        wr(`PCSE_OFS_POL, 8'ha0);
        wr(`PCSE_OFS_SCAL0, 8'h01);
        wr(`PCSE_OFS_SCAL1, 8'h03);
        count(64);
        foreach (cnt[i]) chk_cnt(cnt[i], 0);
        wr(`PCSE_OFS_EN, 8'h0f);
        rd(`PCSE_OFS_PRES, p1);
        rd(`PCSE_OFS_PRES, p2);
        chk_v(p1 != p2, 16'h1);
        for (int k = 0; k < 8; k++) begin
            wr(`PCSE_OFS_CLK, 8'(k * 9));
            settle(8);
            count(1024);
            chk_cnt(cnt[0], 1024 >> k);
            chk_cnt(cnt[1], 256 >> k);
            chk_cnt(cnt[2], 1024 >> k);
            chk_cnt(cnt[3], 128 >> k);
        end
        $display("TB: clock rates done");

        @(posedge ref_clk);
        port_direction_register <= 4'h0;
        port_data <= 4'ha;
        chan_wave <= 4'h1;
        wr(`PCSE_OFS_CLK, 8'hc0);
        settle(8);
        count(1024);
        chk_cnt(cnt[0], 256);
        chk_cnt(cnt[2], 128);
        chk_v(pair_flags, 2'h3);
        chk_v(pin_oe, 4'h5);
        chk_v(pin_out, 4'hb);
        $display("TB: pairing done");

        wr(`PCSE_OFS_EN, 8'h00);
        rd(`PCSE_OFS_PRES, p1);
        settle(10);
        rd(`PCSE_OFS_PRES, p2);
        chk_v(p2, p1);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        settle(2);
        chk_v(pin_oe, 4'h0);
        chk_v(pair_flags, 2'h0);
        foreach (ofs[i]) begin
            rd(ofs[i], rv);
            chk_v(rv, 8'h00);
        end
        $display("TB: second reset done");
        close_out;
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out;
    end

endmodule
